// file: design/tmr_pkg.sv
// constants, modes and helper functions for the compare pin timer
// Notes on behaviour
// - after reset timer levels low, pins undriven
// - pwm mode one: io write skips b/d pins
// - pwm mode two: io write skips cycle pin
// - pwm mode two only on channels 0-2
// - phase counting only on channels 1, 2
// - io setting gives initial and match level
// - start bit clear halts, set runs counter
// - output control sets complementary level, cyclic enable
// - output control also serves reset-sync pwm
// - io control can disable waveform section
// - active level low, error level high
package tmr_pkg;
  localparam int TMR_NCH = 5;
  localparam int TMR_NPIN = 20;
  localparam int TMR_CW = 16;
  localparam int TMR_PPC = 4;
  localparam int TMR_MCH = 3;
  localparam int TMR_MBASE = 12;
  localparam int TMR_NMEN = 8;
  localparam logic [7:0] TMR_ADR_START = 8'h00;
  localparam logic [7:0] TMR_ADR_MEN = 8'h04;
  localparam logic [7:0] TMR_ADR_OCTL = 8'h08;
  localparam logic [7:0] TMR_ADR_FSEL = 8'h0c;
  localparam logic [7:0] TMR_ADR_PDAT = 8'h10;
  localparam logic [7:0] TMR_ADR_PDIR = 8'h14;
  localparam logic [7:0] TMR_ADR_LVL = 8'h18;
  localparam logic [7:0] TMR_ADR_MODE0 = 8'h20;
  localparam logic [7:0] TMR_ADR_IO0 = 8'h40;
  localparam logic [7:0] TMR_ADR_CMP0 = 8'h60;
  localparam logic [7:0] TMR_ADR_CNT0 = 8'h80;
  localparam int TMR_IO_EN_BIT = 3;
  localparam int TMR_IO_INIT_BIT = 2;
  localparam int TMR_OCTL_CYC_BIT = 0;
  localparam int TMR_OCTL_ACT_BIT = 1;
  localparam logic [1:0] TMR_ACT_HOLD = 2'h0;
  localparam logic [1:0] TMR_ACT_LOW = 2'h1;
  localparam logic [1:0] TMR_ACT_HIGH = 2'h2;
  localparam logic [1:0] TMR_ACT_TOG = 2'h3;
  localparam logic [15:0] TMR_IO_RST = 16'h0000;
  localparam logic [15:0] TMR_CMP_RST = 16'hffff;
  localparam logic [1:0] TMR_OCTL_RST = 2'h0;

  typedef enum logic [2:0] {
    TMR_NORMAL = 3'h0,
    TMR_PWM_MODE_ONE = 3'h1,
    TMR_PWM_MODE_TWO = 3'h2,
    TMR_PHASE = 3'h3,
    TMR_COMPLEMENTARY_PWM_MODE = 3'h4,
    TMR_RESET_SYNC_PWM_MODE = 3'h5
  } tmr_mode_e;

  // byte lane merge of a write
  function automatic logic [31:0] tmr_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // which modes a channel may take
  function automatic logic tmr_mode_ok(input int ch, input logic [2:0] m);
    logic r;
    r = 1'b0;
    case (m)
      TMR_NORMAL, TMR_PWM_MODE_ONE: r = 1'b1;
      TMR_PWM_MODE_TWO: r = (ch <= 2);
      TMR_PHASE: r = (ch == 1) || (ch == 2);
      TMR_COMPLEMENTARY_PWM_MODE, TMR_RESET_SYNC_PWM_MODE: r = (ch == TMR_MCH);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // pins the waveform section does not own in a mode
  function automatic logic tmr_pin_skip(input logic [2:0] m, input int p);
    logic r;
    r = 1'b0;
    case (m)
      TMR_PWM_MODE_ONE: r = (p == 1) || (p == 3);
      TMR_PWM_MODE_TWO: r = (p == 0);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] tmr_adr(input logic [7:0] base, input int ch);
    return base + 8'(ch * 4);
  endfunction
endpackage

// file: design/tmr_chan.sv
// one channel up-counter with period compare
`timescale 1ns/10ps
module tmr_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [15:0] period_i,
  output logic [15:0] count_o,
  output logic match_o
);
  // ----------------------------------------
  // counter
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= 16'h0000;
    end else if (run_i) begin
      if (count_o == period_i) begin
        count_o <= 16'h0000;
      end else begin
        count_o <= count_o + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_o <= 1'b0;
    end else begin
      match_o <= run_i && (count_o == period_i);
    end
  end
endmodule

// file: design/tmr_top.sv
// compare pin timer with wishbone registers and pin function select
`timescale 1ns/10ps
module tmr_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [19:0] pin_o,
  output logic [19:0] pin_oe_o
);
  // ----------------------------------------
  // registers and wires
  // ----------------------------------------
  logic [4:0] start_r;
  logic [7:0] men_r;
  logic [1:0] octl_r;
  logic [19:0] fsel_r;
  logic [19:0] pdat_r;
  logic [19:0] pdir_r;
  logic [2:0] mode_r [5];
  logic [15:0] io_r [5];
  logic [15:0] cmp_r [5];
  logic [15:0] cnt [5];
  logic [4:0] match;
  logic [19:0] level_r;
  logic cwave_r;
  logic [19:0] tmr_lvl;
  logic [7:0] adr;
  logic wr_fire;
  logic [31:0] rd_nxt;
  logic [4:0] mode_wr;
  logic [4:0] io_wr;
  logic [2:0] mode_nxt [5];
  logic [15:0] io_nxt [5];
  logic ch3_pwm;

  assign adr = wb_adr_i[7:0];
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && (wb_adr_i[31:8] == 24'h000000);
  assign ch3_pwm = (mode_r[3] == tmr_pkg::TMR_COMPLEMENTARY_PWM_MODE) || (mode_r[3] == tmr_pkg::TMR_RESET_SYNC_PWM_MODE);

  // ----------------------------------------
  // channel counters
  // ----------------------------------------
  for (genvar c = 0; c < tmr_pkg::TMR_NCH; c++) begin : g_ch
    tmr_chan u_chan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(start_r[c]),
      .period_i(cmp_r[c]),
      .count_o(cnt[c]),
      .match_o(match[c])
    );
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  always_comb begin
    logic [31:0] m;
    m = 32'h00000000;
    for (int c = 0; c < tmr_pkg::TMR_NCH; c++) begin
      m = tmr_pkg::tmr_merge({29'h0, mode_r[c]}, wb_dat_i, wb_sel_i);
      mode_nxt[c] = m[2:0];
      // mode is taken only while stopped and only if legal here
      mode_wr[c] = wr_fire && (adr == tmr_pkg::tmr_adr(tmr_pkg::TMR_ADR_MODE0, c)) &&
                   !start_r[c] && tmr_pkg::tmr_mode_ok(c, m[2:0]);
      m = tmr_pkg::tmr_merge({16'h0, io_r[c]}, wb_dat_i, wb_sel_i);
      io_nxt[c] = m[15:0];
      io_wr[c] = wr_fire && (adr == tmr_pkg::tmr_adr(tmr_pkg::TMR_ADR_IO0, c));
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_comb begin
    rd_nxt = 32'h00000000;
    case (adr)
      tmr_pkg::TMR_ADR_START: rd_nxt = {27'h0, start_r};
      tmr_pkg::TMR_ADR_MEN: rd_nxt = {24'h0, men_r};
      tmr_pkg::TMR_ADR_OCTL: rd_nxt = {30'h0, octl_r};
      tmr_pkg::TMR_ADR_FSEL: rd_nxt = {12'h0, fsel_r};
      tmr_pkg::TMR_ADR_PDAT: rd_nxt = {12'h0, pdat_r};
      tmr_pkg::TMR_ADR_PDIR: rd_nxt = {12'h0, pdir_r};
      tmr_pkg::TMR_ADR_LVL: rd_nxt = {12'h0, tmr_lvl};
      default: rd_nxt = 32'h00000000;
    endcase
    for (int c = 0; c < tmr_pkg::TMR_NCH; c++) begin
      if (adr == tmr_pkg::tmr_adr(tmr_pkg::TMR_ADR_MODE0, c)) begin
        rd_nxt = {29'h0, mode_r[c]};
      end
      if (adr == tmr_pkg::tmr_adr(tmr_pkg::TMR_ADR_IO0, c)) begin
        rd_nxt = {16'h0, io_r[c]};
      end
      if (adr == tmr_pkg::tmr_adr(tmr_pkg::TMR_ADR_CMP0, c)) begin
        rd_nxt = {16'h0, cmp_r[c]};
      end
      if (adr == tmr_pkg::tmr_adr(tmr_pkg::TMR_ADR_CNT0, c)) begin
        rd_nxt = {16'h0, cnt[c]};
      end
    end
    if (wb_adr_i[31:8] != 24'h000000) begin
      rd_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= rd_nxt;
    end
  end

  // ----------------------------------------
  // global registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    logic [31:0] m;
    m = tmr_pkg::tmr_merge({27'h0, start_r}, wb_dat_i, wb_sel_i);
    if (rst_i) begin
      start_r <= 5'h00;
    end else if (wr_fire && adr == tmr_pkg::TMR_ADR_START) begin
      start_r <= m[4:0];
    end
  end

  always_ff @(posedge clk_i) begin
    logic [31:0] m;
    m = tmr_pkg::tmr_merge({24'h0, men_r}, wb_dat_i, wb_sel_i);
    if (rst_i) begin
      men_r <= 8'h00;
    end else if (wr_fire && adr == tmr_pkg::TMR_ADR_MEN) begin
      men_r <= m[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    logic [31:0] m;
    m = tmr_pkg::tmr_merge({30'h0, octl_r}, wb_dat_i, wb_sel_i);
    if (rst_i) begin
      octl_r <= tmr_pkg::TMR_OCTL_RST;
    end else if (wr_fire && adr == tmr_pkg::TMR_ADR_OCTL) begin
      octl_r <= m[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    logic [31:0] m0;
    logic [31:0] m1;
    logic [31:0] m2;
    m0 = tmr_pkg::tmr_merge({12'h0, fsel_r}, wb_dat_i, wb_sel_i);
    m1 = tmr_pkg::tmr_merge({12'h0, pdat_r}, wb_dat_i, wb_sel_i);
    m2 = tmr_pkg::tmr_merge({12'h0, pdir_r}, wb_dat_i, wb_sel_i);
    if (rst_i) begin
      fsel_r <= 20'h00000;
      pdat_r <= 20'h00000;
      pdir_r <= 20'h00000;
    end else if (wr_fire) begin
      if (adr == tmr_pkg::TMR_ADR_FSEL) begin
        fsel_r <= m0[19:0];
      end
      if (adr == tmr_pkg::TMR_ADR_PDAT) begin
        pdat_r <= m1[19:0];
      end
      if (adr == tmr_pkg::TMR_ADR_PDIR) begin
        pdir_r <= m2[19:0];
      end
    end
  end

  // ----------------------------------------
  // channel registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    logic [31:0] m;
    m = 32'h00000000;
    for (int c = 0; c < tmr_pkg::TMR_NCH; c++) begin
      m = tmr_pkg::tmr_merge({16'h0, cmp_r[c]}, wb_dat_i, wb_sel_i);
      if (rst_i) begin
        mode_r[c] <= tmr_pkg::TMR_NORMAL;
        io_r[c] <= tmr_pkg::TMR_IO_RST;
        cmp_r[c] <= tmr_pkg::TMR_CMP_RST;
      end else begin
        if (mode_wr[c]) begin
          mode_r[c] <= mode_nxt[c];
        end
        if (io_wr[c]) begin
          io_r[c] <= io_nxt[c];
        end
        if (wr_fire && adr == tmr_pkg::tmr_adr(tmr_pkg::TMR_ADR_CMP0, c)) begin
          cmp_r[c] <= m[15:0];
        end
      end
    end
  end

  // ----------------------------------------
  // waveform section levels
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    int i;
    logic [3:0] nb;
    i = 0;
    nb = 4'h0;
    for (int c = 0; c < tmr_pkg::TMR_NCH; c++) begin
      for (int p = 0; p < tmr_pkg::TMR_PPC; p++) begin
        i = c * tmr_pkg::TMR_PPC + p;
        nb = io_nxt[c][4*p +: 4];
        if (rst_i) begin
          level_r[i] <= 1'b0;
        end else if (mode_wr[c]) begin
          level_r[i] <= 1'b0;
        end else if (io_wr[c]) begin
          // rewrite re-initialises without a mode write
          if (nb[tmr_pkg::TMR_IO_EN_BIT] && !tmr_pkg::tmr_pin_skip(mode_r[c], p) &&
              (c < tmr_pkg::TMR_MCH || men_r[i - tmr_pkg::TMR_MBASE])) begin
            level_r[i] <= nb[tmr_pkg::TMR_IO_INIT_BIT];
          end
        end else if (match[c] && start_r[c] && io_r[c][4*p + tmr_pkg::TMR_IO_EN_BIT] &&
                     mode_r[c] != tmr_pkg::TMR_COMPLEMENTARY_PWM_MODE && mode_r[c] != tmr_pkg::TMR_RESET_SYNC_PWM_MODE &&
                     !tmr_pkg::tmr_pin_skip(mode_r[c], p)) begin
          case (io_r[c][4*p +: 2])
            tmr_pkg::TMR_ACT_LOW: level_r[i] <= 1'b0;
            tmr_pkg::TMR_ACT_HIGH: level_r[i] <= 1'b1;
            tmr_pkg::TMR_ACT_TOG: level_r[i] <= !level_r[i];
            default: level_r[i] <= level_r[i];
          endcase
        end
      end
    end
  end

  // complementary / reset-sync wave, back to initial value when stopped
  always_ff @(posedge clk_i) begin
    if (rst_i || !start_r[tmr_pkg::TMR_MCH]) begin
      cwave_r <= 1'b0;
    end else if (match[tmr_pkg::TMR_MCH] && ch3_pwm) begin
      cwave_r <= !cwave_r;
    end
  end

  always_comb begin
    logic act;
    logic pos;
    act = octl_r[tmr_pkg::TMR_OCTL_ACT_BIT];
    pos = cwave_r ? act : !act;
    for (int i = 0; i < tmr_pkg::TMR_NPIN; i++) begin
      // a disabled section holds its pin level low, unless channel 3 pwm owns pins 12-19
      tmr_lvl[i] = io_r[i / 4][4*(i % 4) + tmr_pkg::TMR_IO_EN_BIT] && level_r[i];
    end
    if (ch3_pwm) begin
      tmr_lvl[12] = octl_r[tmr_pkg::TMR_OCTL_CYC_BIT] && cwave_r;
      tmr_lvl[13] = pos;
      tmr_lvl[14] = 1'b0;
      tmr_lvl[15] = !pos;
      tmr_lvl[16] = pos;
      tmr_lvl[17] = pos;
      tmr_lvl[18] = !pos;
      tmr_lvl[19] = !pos;
    end
    for (int k = 0; k < tmr_pkg::TMR_NMEN; k++) begin
      tmr_lvl[tmr_pkg::TMR_MBASE + k] = tmr_lvl[tmr_pkg::TMR_MBASE + k] && men_r[k];
    end
  end

  // ----------------------------------------
  // pin function select
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 20'h00000;
      pin_oe_o <= 20'h00000;
    end else begin
      // port mode drives software level from pdat_r, timer mode drives the timer level
      pin_o <= (fsel_r & tmr_lvl) | (~fsel_r & pdat_r);
      pin_oe_o <= fsel_r | pdir_r;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  reset_pins_off_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> (pin_oe_o == 20'h00000) && (pin_o == 20'h00000))
    else $error("pins driven after reset");

  pwm_mode_one_keep_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
    io_wr[1] && mode_r[1] == tmr_pkg::TMR_PWM_MODE_ONE |=> $stable(level_r[5]) && $stable(level_r[7]))
    else $error("pwm_mode_one b pin initialised");

  pwm_mode_two_keep_a_a: assert property (@(posedge clk_i) disable iff (rst_i)
    io_wr[2] && mode_r[2] == tmr_pkg::TMR_PWM_MODE_TWO |=> $stable(level_r[8]))
    else $error("pwm_mode_two cycle pin initialised");

  pwm_mode_two_ch3_refused_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 mode_r[3] != tmr_pkg::TMR_PWM_MODE_TWO)
    else $error("pwm_mode_two on channel 3");

  phase_ch0_refused_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_r[0] != tmr_pkg::TMR_PHASE && mode_r[4] != tmr_pkg::TMR_PHASE)
    else $error("phase mode on bad channel");

  ch3_master_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !men_r[0] |-> (!tmr_lvl[12] and (fsel_r[12] |=> !pin_o[12])))
    else $error("channel 3 pin without master enable");

  io_init_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    io_wr[0] && io_nxt[0][3] && mode_r[0] == tmr_pkg::TMR_NORMAL
    |=> level_r[0] == $past(io_nxt[0][2]))
    else $error("initial level not taken");

  match_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    match[0] && start_r[0] && !io_wr[0] && !mode_wr[0] && mode_r[0] == tmr_pkg::TMR_NORMAL &&
    io_r[0][3] && io_r[0][1:0] == tmr_pkg::TMR_ACT_LOW |=> !level_r[0])
    else $error("match did not drive low");

  stop_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i && !start_r[0] |=> $stable(cnt[0]))
    else $error("counter moved while stopped");

  run_moves_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_r[0] && cnt[0] != cmp_r[0] |=> cnt[0] == $past(cnt[0]) + 16'h0001)
    else $error("counter stuck while running");

  complementary_pwm_mode_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ch3_pwm && men_r[1] && men_r[3]
    |-> tmr_lvl[13] == (cwave_r ~^ octl_r[1]) && tmr_lvl[15] != tmr_lvl[13])
    else $error("complementary level wrong");

  wave_disable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_r[0] == tmr_pkg::TMR_NORMAL && !io_r[0][3] |-> !tmr_lvl[0])
    else $error("disabled section drives pin");

  mode_locked_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_r[0] && $past(start_r[0]) |-> $stable(mode_r[0]))
    else $error("mode changed while counting");
endmodule

// file: dv/tmr_pins_model.sv
// pull-up line model of the external power-stage pins
`timescale 1ns/10ps
module tmr_pins_model (
  input wire logic [19:0] pin_i,
  input wire logic [19:0] oe_i,
  output logic [19:0] line_o
);
  // ----------------------------------------
  // line levels
  // ----------------------------------------
  // undriven lines rest at the inactive level through the stage pull-up
  always_comb begin
    for (int k = 0; k < 20; k++) begin
      line_o[k] = oe_i[k] ? pin_i[k] : 1'b1;
    end
  end
endmodule

// file: dv/tb.sv
// self-checking bench for the compare pin timer
`timescale 1ns/10ps
module tb;
  logic clk_i, rst_i, cyc, stb, we, ack;
  logic [31:0] adr, wdat, rdat, dat_o;
  logic [3:0] sel;
  logic [19:0] pin, pin_oe, line;
  int fails, n_tests;

  tmr_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pin_o(pin), .pin_oe_o(pin_oe));
  tmr_pins_model stage (.pin_i(pin), .oe_i(pin_oe), .line_o(line));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, {24'h0, a}, d);
  endtask

  task rd(input logic [7:0] a);
    xfer(1'b0, {24'h0, a}, 32'h0);
  endtask

  task settle;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    settle;
    chk(32'(pin), 32'h0, "pin level after reset");
    chk(32'(pin_oe), 32'h0, "pins driven after reset");
    chk(32'(line), 32'h000fffff, "lines not floating high");
    rd(tmr_pkg::TMR_ADR_LVL);
    chk(rdat, 32'h0, "timer levels after reset");
    rd(tmr_pkg::TMR_ADR_CMP0);
    chk(rdat, 32'h0000ffff, "compare reset value");
    xfer(1'b0, 32'h00000100, 32'h0);
    chk(rdat, 32'h0, "unmapped read");
  endtask

  task t_normal;
    logic [31:0] cnt;
    int n;
    wr(tmr_pkg::TMR_ADR_CMP0, 32'h3);
    // second pass restarts in the same mode without a mode write
    for (int r = 0; r < 2; r++) begin
      wr(tmr_pkg::TMR_ADR_IO0, 32'h0000000d);
      rd(tmr_pkg::TMR_ADR_LVL);
      chk(32'(rdat[0]), 32'h1, "initial level");
      wr(tmr_pkg::TMR_ADR_FSEL, 32'h1);
      settle;
      chk(32'({pin_oe[0], pin[0]}), 32'h3, "timer pin selected high");
      wr(tmr_pkg::TMR_ADR_START, 32'h1);
      n = 0;
      do begin
        rd(tmr_pkg::TMR_ADR_LVL);
        n++;
      end while (rdat[0] !== 1'b0 && n < 20);
      chk(32'(rdat[0]), 32'h0, "level on match");
      settle;
      chk(32'(line[0]), 32'h0, "line low on match");
      wr(tmr_pkg::TMR_ADR_PDAT, 32'h1);
      wr(tmr_pkg::TMR_ADR_PDIR, 32'h1);
      wr(tmr_pkg::TMR_ADR_FSEL, 32'h0);
      settle;
      chk(32'({pin_oe[0], line[0]}), 32'h3, "port drives inactive level");
      wr(tmr_pkg::TMR_ADR_START, 32'h0);
      rd(tmr_pkg::TMR_ADR_CNT0);
      cnt = rdat;
      repeat (5) @(posedge clk_i);
      rd(tmr_pkg::TMR_ADR_CNT0);
      chk(rdat, cnt, "counter halted");
    end
    wr(tmr_pkg::TMR_ADR_PDIR, 32'h0);
  endtask

  task t_pwm;
    wr(tmr_pkg::TMR_ADR_MODE0 + 8'h04, 32'h1);
    wr(tmr_pkg::TMR_ADR_IO0 + 8'h04, 32'h0000dddd);
    rd(tmr_pkg::TMR_ADR_LVL);
    chk(32'(rdat[7:4]), 32'h5, "pwm one b and d skipped");
    wr(tmr_pkg::TMR_ADR_MODE0 + 8'h08, 32'h2);
    wr(tmr_pkg::TMR_ADR_IO0 + 8'h08, 32'h0000dddd);
    rd(tmr_pkg::TMR_ADR_LVL);
    chk(32'(rdat[11:8]), 32'he, "pwm two cycle pin skipped");
  endtask

  task t_modes;
    logic [7:0] ch_t[4];
    logic [2:0] md_t[4];
    logic [2:0] ex_t[4];
    ch_t = '{8'h0c, 8'h00, 8'h04, 8'h00};
    md_t = '{3'h2, 3'h3, 3'h3, 3'h2};
    ex_t = '{3'h0, 3'h0, 3'h3, 3'h2};
    for (int i = 0; i < 4; i++) begin
      wr(tmr_pkg::TMR_ADR_MODE0 + ch_t[i], 32'(md_t[i]));
      rd(tmr_pkg::TMR_ADR_MODE0 + ch_t[i]);
      chk(rdat, 32'(ex_t[i]), "mode legality per channel");
    end
    wr(tmr_pkg::TMR_ADR_START, 32'h1);
    wr(tmr_pkg::TMR_ADR_MODE0, 32'h1);
    rd(tmr_pkg::TMR_ADR_MODE0);
    chk(rdat, 32'h2, "mode write while running");
    wr(tmr_pkg::TMR_ADR_START, 32'h0);
  endtask

  task t_ch34;
    wr(tmr_pkg::TMR_ADR_IO0 + 8'h0c, 32'h0000dddd);
    rd(tmr_pkg::TMR_ADR_LVL);
    chk(32'(rdat[15:12]), 32'h0, "ch3 init without master enable");
    wr(tmr_pkg::TMR_ADR_MEN, 32'hff);
    wr(tmr_pkg::TMR_ADR_IO0 + 8'h0c, 32'h0000dddd);
    rd(tmr_pkg::TMR_ADR_LVL);
    chk(32'(rdat[15:12]), 32'hf, "ch3 init with master enable");
    wr(tmr_pkg::TMR_ADR_IO0 + 8'h0c, 32'h0);
    rd(tmr_pkg::TMR_ADR_LVL);
    chk(32'(rdat[15:12]), 32'h0, "waveform section disabled");
    wr(tmr_pkg::TMR_ADR_MEN, 32'h0);
    wr(tmr_pkg::TMR_ADR_OCTL, 32'h1);
    wr(tmr_pkg::TMR_ADR_MODE0 + 8'h0c, 32'h4);
    wr(tmr_pkg::TMR_ADR_MEN, 32'hff);
    rd(tmr_pkg::TMR_ADR_LVL);
    chk(32'(rdat[19:12]), 32'h32, "complementary levels");
    wr(tmr_pkg::TMR_ADR_MEN, 32'h0);
    wr(tmr_pkg::TMR_ADR_OCTL, 32'h3);
    wr(tmr_pkg::TMR_ADR_MODE0 + 8'h0c, 32'h5);
    wr(tmr_pkg::TMR_ADR_MEN, 32'hff);
    rd(tmr_pkg::TMR_ADR_LVL);
    chk(32'(rdat[19:12]), 32'hc8, "reset-sync levels");
    wr(tmr_pkg::TMR_ADR_FSEL, 32'h000ff000);
    settle;
    chk(32'(line[19:12]), 32'hc8, "reset-sync lines");
  endtask

  // reset again while pins are driven
  task t_rerst;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle;
    chk(32'(pin_oe), 32'h0, "pins driven after second reset");
    chk(32'(line), 32'h000fffff, "lines after second reset");
    rd(tmr_pkg::TMR_ADR_LVL);
    chk(rdat, 32'h0, "levels after second reset");
  endtask

  // ----------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    wdat = 32'h0;
    sel = 4'h0;
    fails = 0;
    n_tests = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_normal;
    t_pwm;
    t_modes;
    t_ch34;
    t_rerst;
    report_and_stop;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    $display("unexpected %0t watchdog expired", $time);
    report_and_stop;
  end
endmodule
